// ===== hw/bsl_consts.svh
`ifndef BSL_CONSTS_SVH
`define BSL_CONSTS_SVH
`define BSL_DATA_W 64
`define BSL_FIFO_DEPTH 32
`define BSL_FRAME_W 66
`define BSL_CRC_W 6
`define BSL_CRC_POLY 6'h03
`define BSL_REG_W 8
`define BSL_REG_MSB 3'h7
`define BSL_LINK_MAX_KBPS 10000
`define BSL_CLK_NS 100
`define BSL_TOUT_NS 20000
`define BSL_TOUT_CYC ((`BSL_TOUT_NS + `BSL_CLK_NS - 1) / `BSL_CLK_NS)
`endif

// ===== hw/bsl_pkg.sv
package bsl_pkg;
  // Link side sequence, one-hot
  typedef enum logic [6:0] {
    LK_IDLE = 7'h01,
    LK_ACK = 7'h02,
    LK_START = 7'h04,
    LK_DATA = 7'h08,
    LK_CRC = 7'h10,
    LK_STOP = 7'h20,
    LK_DONE = 7'h40
  } bsl_link_st_type;

  // System side sequence, one-hot
  typedef enum logic [1:0] {
    SY_TOUT = 2'h1,
    SY_READY = 2'h2
  } bsl_sys_st_type;

  typedef struct packed {
    bsl_link_st_type st;
    logic frame;
    logic sl;
    logic [65:0] sh;
    logic [6:0] cnt;
    logic [5:0] crc;
  } bsl_link_reg_type;

  typedef struct packed {
    bsl_sys_st_type st;
    logic [7:0] cnt;
    logic link_rst;
    logic ready;
    logic xfer_rdy;
    logic [63:0] word;
    logic mc_bit;
    logic mc_en;
    logic reg_bit;
    logic [2:0] reg_idx;
    logic capture;
    logic underrun;
  } bsl_sys_reg_type;
endpackage

// ===== hw/bsl_sync2.sv
`timescale 1ns/1ns
`default_nettype none
module bsl_sync2 #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bsl_sync_reg_type;
  bsl_sync_reg_type q;
  bsl_sync_reg_type d;

  // First stage feeds only the second
  always_comb begin
    d.s1 = i_d;
    d.s2 = q.s1;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_q = q.s2;
endmodule // bsl_sync2
`default_nettype wire

// ===== hw/bsl_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module bsl_fifo #(
  parameter int W = 64,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  input wire logic [W-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [W-1:0] o_out_data,
  input wire logic i_out_ready
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } bsl_fifo_reg_type;
  bsl_fifo_reg_type q;
  bsl_fifo_reg_type d;
  logic push;
  logic pop;

  // Full and empty straight from the fill count
  assign o_in_ready = (q.cnt != (AW+1)'(DEPTH));
  assign o_out_valid = (q.cnt != '0);
  assign o_out_data = q.mem[q.rp];
  assign push = i_in_valid && o_in_ready;
  assign pop = i_out_ready && o_out_valid;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = i_in_data;
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    if (push && !pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Never count past the depth
  AST_FIFO_BOUND: assert property (@(posedge i_clk) disable iff (i_rst)
    q.cnt <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule // bsl_fifo
`default_nettype wire

// ===== hw/bsl_slave.sv
`timescale 1ns/1ns
`default_nettype none
`include "bsl_consts.svh"
module bsl_slave (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_master_clock_line,
  output logic o_slave_return_line,
  input wire logic i_pos_valid,
  input wire logic [`BSL_DATA_W-1:0] i_pos_data,
  output logic o_pos_ready,
  input wire logic i_mc_enable,
  input wire logic i_mc_bit,
  input wire logic [`BSL_REG_W-1:0] i_reg_byte,
  output logic o_capture,
  output logic o_underrun
);
  localparam int TOUT_CYC = `BSL_TOUT_CYC;
  localparam logic [7:0] TOUT_LAST = 8'(TOUT_CYC - 1);
  localparam logic [6:0] CRC_LAST = 7'(`BSL_CRC_W);
  localparam logic [6:0] DATA_BASE = 7'(`BSL_FRAME_W - 1);

  bsl_pkg::bsl_sys_reg_type s_q;
  bsl_pkg::bsl_sys_reg_type s_d;
  bsl_pkg::bsl_link_reg_type l_q;
  bsl_pkg::bsl_link_reg_type l_d;

  logic fifo_valid;
  logic [`BSL_DATA_W-1:0] fifo_data;
  logic fifo_pop;
  logic frame_s;
  logic done_s;
  logic rdy_s;
  logic link_rst;
  logic [6:0] data_last;
  logic crc_fb;

  assign link_rst = s_q.link_rst;

  // Samples wait here until a frame asks for one
  bsl_fifo #(
    .W(`BSL_DATA_W),
    .DEPTH(`BSL_FIFO_DEPTH),
    .AW(5)
  ) u_fifo (
    .i_clk(i_clk_sys),
    .i_rst(i_rst),
    .i_in_valid(i_pos_valid),
    .i_in_data(i_pos_data),
    .o_in_ready(o_pos_ready),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_data),
    .i_out_ready(fifo_pop)
  );

  // Link levels into the system clock
  bsl_sync2 #(
    .W(2)
  ) u_sync_sys (
    .i_clk(i_clk_sys),
    .i_rst(i_rst),
    .i_d({l_q.frame, l_q.st == bsl_pkg::LK_DONE}),
    .o_q({frame_s, done_s})
  );

  // Snapshot-ready level into the link clock
  bsl_sync2 #(
    .W(1)
  ) u_sync_link (
    .i_clk(i_master_clock_line),
    .i_rst(link_rst),
    .i_d(s_q.xfer_rdy),
    .o_q(rdy_s)
  );

  // System side: snapshot on capture, then hold the link off for the timeout
  always_comb begin
    s_d = s_q;
    s_d.capture = 1'b0;
    s_d.underrun = 1'b0;
    fifo_pop = 1'b0;
    case (s_q.st)
      bsl_pkg::SY_TOUT: begin
        s_d.link_rst = 1'b1;
        s_d.ready = 1'b0;
        s_d.xfer_rdy = 1'b0;
        if (s_q.cnt == TOUT_LAST) begin
          s_d.st = bsl_pkg::SY_READY;
          s_d.link_rst = 1'b0;
          s_d.ready = 1'b1;
          s_d.cnt = 8'h00;
        end else begin
          s_d.cnt = s_q.cnt + 8'h01;
        end
      end
      bsl_pkg::SY_READY: begin
        if (frame_s && !s_q.xfer_rdy) begin
          // Sensor word and slow bit frozen together
          if (fifo_valid) begin
            s_d.word = fifo_data;
            fifo_pop = 1'b1;
          end else begin
            s_d.underrun = 1'b1;
          end
          s_d.mc_en = i_mc_enable;
          s_d.mc_bit = i_mc_bit & i_mc_enable;
          // Register byte goes out one bit per frame, MSB first
          s_d.reg_bit = i_reg_byte[`BSL_REG_MSB - s_q.reg_idx];
          s_d.reg_idx = s_q.reg_idx + 3'h1;
          s_d.xfer_rdy = 1'b1;
          s_d.capture = 1'b1;
        end
        if (done_s) begin
          s_d.st = bsl_pkg::SY_TOUT;
          s_d.link_rst = 1'b1;
          s_d.ready = 1'b0;
          s_d.cnt = 8'h00;
        end
      end
      default: begin
        s_d.st = bsl_pkg::SY_TOUT;
        s_d.link_rst = 1'b1;
        s_d.cnt = 8'h00;
      end
    endcase
  end

  // Reset starts in timeout so the link comes up quiet
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '{st: bsl_pkg::SY_TOUT, link_rst: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // Bits after the start bit: register bit, data, optional slow bit
  assign data_last = DATA_BASE + {6'h00, s_q.mc_en};
  assign crc_fb = l_q.crc[5] ^ l_q.sh[`BSL_FRAME_W-1];

  // Link side: one bit per master clock edge, no setup phase needed
  always_comb begin
    l_d = l_q;
    case (l_q.st)
      bsl_pkg::LK_IDLE: begin
        // First edge is the capture trigger; answer at once
        l_d.frame = 1'b1;
        l_d.st = bsl_pkg::LK_ACK;
        l_d.sl = 1'b0;
      end
      bsl_pkg::LK_ACK: begin
        l_d.sl = 1'b0;
        if (rdy_s) begin
          // Snapshot is stable while the ready level is high
          l_d.st = bsl_pkg::LK_START;
          l_d.sl = 1'b1;
          l_d.sh = {s_q.reg_bit, s_q.word, s_q.mc_bit};
          l_d.cnt = 7'h00;
          l_d.crc = '0;
        end
      end
      bsl_pkg::LK_START: begin
        l_d.st = bsl_pkg::LK_DATA;
        l_d.sl = l_q.sh[`BSL_FRAME_W-1];
        l_d.sh = {l_q.sh[`BSL_FRAME_W-2:0], 1'b0};
        l_d.crc = {l_q.crc[4:0], 1'b0} ^ (crc_fb ? `BSL_CRC_POLY : 6'h00);
        l_d.cnt = 7'h01;
      end
      bsl_pkg::LK_DATA: begin
        if (l_q.cnt == data_last) begin
          // CRC goes out inverted, MSB first
          l_d.st = bsl_pkg::LK_CRC;
          l_d.sl = ~l_q.crc[5];
          l_d.crc = {l_q.crc[4:0], 1'b0};
          l_d.cnt = 7'h01;
        end else begin
          l_d.sl = l_q.sh[`BSL_FRAME_W-1];
          l_d.sh = {l_q.sh[`BSL_FRAME_W-2:0], 1'b0};
          l_d.crc = {l_q.crc[4:0], 1'b0} ^ (crc_fb ? `BSL_CRC_POLY : 6'h00);
          l_d.cnt = l_q.cnt + 7'h01;
        end
      end
      bsl_pkg::LK_CRC: begin
        if (l_q.cnt == CRC_LAST) begin
          l_d.st = bsl_pkg::LK_STOP;
          l_d.sl = 1'b0;
        end else begin
          l_d.sl = ~l_q.crc[5];
          l_d.crc = {l_q.crc[4:0], 1'b0};
          l_d.cnt = l_q.cnt + 7'h01;
        end
      end
      bsl_pkg::LK_STOP: begin
        // Line stays low until the timeout releases it
        l_d.st = bsl_pkg::LK_DONE;
        l_d.sl = 1'b0;
      end
      bsl_pkg::LK_DONE: begin
        l_d.sl = 1'b0;
      end
      default: begin
        l_d.st = bsl_pkg::LK_DONE;
        l_d.sl = 1'b0;
      end
    endcase
  end

  // Link clock stops between frames, so the system side ends each frame
  // by holding this reset through the timeout
  always_ff @(posedge i_master_clock_line or posedge link_rst) begin
    if (link_rst) begin
      l_q <= '{st: bsl_pkg::LK_IDLE, default: '0};
    end else begin
      l_q <= l_d;
    end
  end

  // Idle level is the system ready flag, frame bits come from the link
  assign o_slave_return_line = l_q.frame ? l_q.sl : s_q.ready;
  assign o_capture = s_q.capture;
  assign o_underrun = s_q.underrun;

  // Frame steps as named sequences
  sequence seq_ack_done;
    l_q.st == bsl_pkg::LK_ACK && rdy_s;
  endsequence

  sequence seq_start_bit;
    l_q.st == bsl_pkg::LK_START && l_q.sl;
  endsequence

  sequence seq_crc_run;
    (l_q.st == bsl_pkg::LK_CRC)[*6] ##1 (l_q.st == bsl_pkg::LK_STOP && !l_q.sl);
  endsequence

  AST_ANSWER_ON_EDGE: assert property (@(posedge i_master_clock_line) disable iff (link_rst)
    $rose(l_q.frame) |-> l_q.st == bsl_pkg::LK_ACK && !o_slave_return_line)
    else $error("no acknowledge after first clock edge");

  AST_NO_PWM_SETUP: assert property (@(posedge i_master_clock_line) disable iff (link_rst)
    seq_ack_done |=> seq_start_bit)
    else $error("start bit did not follow ready snapshot");

  AST_ONE_BIT_PER_EDGE: assert property (@(posedge i_master_clock_line) disable iff (link_rst)
    (l_q.st == bsl_pkg::LK_DATA && $past(l_q.st) == bsl_pkg::LK_DATA)
    |-> l_q.cnt == $past(l_q.cnt) + 7'h01)
    else $error("data bit count skipped");

  AST_REG_BIT_FIRST: assert property (@(posedge i_master_clock_line) disable iff (link_rst)
    seq_start_bit |=> l_q.sl == s_q.reg_bit)
    else $error("register section bit not first after start");

  AST_DATA_LENGTH: assert property (@(posedge i_master_clock_line) disable iff (link_rst)
    ($past(l_q.st) == bsl_pkg::LK_DATA && l_q.st == bsl_pkg::LK_CRC)
    |-> $past(l_q.cnt) == 7'h41 + {6'h00, s_q.mc_en})
    else $error("wrong number of data bits");

  AST_CRC_LENGTH: assert property (@(posedge i_master_clock_line) disable iff (link_rst)
    $rose(l_q.st == bsl_pkg::LK_CRC) |-> seq_crc_run)
    else $error("crc field not six bits then stop");

  AST_STOP_THEN_LOW: assert property (@(posedge i_master_clock_line) disable iff (link_rst)
    l_q.st == bsl_pkg::LK_STOP |=> l_q.st == bsl_pkg::LK_DONE && !o_slave_return_line)
    else $error("line not low after stop bit");

  AST_REG_ADVANCE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_q.capture |-> s_q.reg_idx == $past(s_q.reg_idx) + 3'h1)
    else $error("register bit index did not advance");

  AST_MC_OPTION: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (s_q.capture && !s_q.mc_en) |-> !s_q.mc_bit)
    else $error("slow bit set while disabled");

  AST_SNAPSHOT: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (s_q.st == bsl_pkg::SY_READY && frame_s && !s_q.xfer_rdy && !done_s)
    |=> s_q.capture && s_q.xfer_rdy && s_q.mc_bit == ($past(i_mc_bit) && $past(i_mc_enable)))
    else $error("capture did not freeze both sections");

  AST_TIMEOUT_LEN: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ($past(s_q.st) == bsl_pkg::SY_TOUT && s_q.st == bsl_pkg::SY_READY)
    |-> $past(s_q.cnt) == TOUT_LAST && o_slave_return_line)
    else $error("timeout length wrong or line not ready");

  AST_BUSY_IN_TIMEOUT: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_q.st == bsl_pkg::SY_TOUT |-> !o_slave_return_line)
    else $error("ready shown during timeout");

  // Acknowledge holds the line low
  AST_ACK_LOW: assert property (@(posedge i_master_clock_line) disable iff (link_rst)
    l_q.st == bsl_pkg::LK_ACK |-> !o_slave_return_line)
    else $error("line not low during acknowledge");

  // Start bit only once the snapshot handshake is done
  AST_START_AFTER_ACK: assert property (@(posedge i_master_clock_line) disable iff (link_rst)
    l_q.st == bsl_pkg::LK_START |-> $past(l_q.st) == bsl_pkg::LK_ACK)
    else $error("start bit without acknowledge");

  // CRC counter stays inside its field
  AST_CRC_COUNT_RANGE: assert property (@(posedge i_master_clock_line) disable iff (link_rst)
    l_q.st == bsl_pkg::LK_CRC |-> l_q.cnt != 7'h00 && l_q.cnt <= CRC_LAST)
    else $error("crc counter out of range");

  // Idle link has not yet seen a trigger
  AST_IDLE_NO_FRAME: assert property (@(posedge i_master_clock_line) disable iff (link_rst)
    l_q.st == bsl_pkg::LK_IDLE |-> !l_q.frame)
    else $error("frame flag set while idle");

  // Finished frame keeps the line low until the timeout takes over
  AST_DONE_LINE_LOW: assert property (@(posedge i_master_clock_line) disable iff (link_rst)
    l_q.st == bsl_pkg::LK_DONE |-> l_q.frame && !o_slave_return_line)
    else $error("line not low after frame end");

  // One capture pulse per frame
  AST_CAPTURE_PULSE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_q.capture |=> !s_q.capture)
    else $error("capture pulse longer than one cycle");

  // Underrun is only reported at a capture
  AST_UNDERRUN_WITH_CAPTURE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_q.underrun |-> s_q.capture)
    else $error("underrun without capture");

  // Link reads the snapshot freely, so it must not move while offered
  AST_SNAPSHOT_STEADY: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (s_q.xfer_rdy && $past(s_q.xfer_rdy)) |-> $stable(s_q.word) && $stable(s_q.mc_bit) && $stable(s_q.reg_bit))
    else $error("snapshot changed while offered");

  // Timeout counts one per cycle
  AST_TOUT_STEP: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (s_q.st == bsl_pkg::SY_TOUT && s_q.cnt != 8'h00) |-> s_q.cnt == $past(s_q.cnt) + 8'h01)
    else $error("timeout counter skipped");

  // Link held in reset and busy shown for the whole timeout
  AST_TOUT_HOLDS_LINK: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_q.st == bsl_pkg::SY_TOUT |-> s_q.link_rst && !s_q.ready)
    else $error("link not held during timeout");

  // Seen end of frame starts the timeout at once
  AST_DONE_ENDS_FRAME: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (s_q.st == bsl_pkg::SY_READY && done_s) |=> s_q.st == bsl_pkg::SY_TOUT && !o_slave_return_line)
    else $error("frame end did not start timeout");

  // A buffered word leaves only as a fresh snapshot
  AST_POP_AT_CAPTURE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    fifo_pop |=> s_q.capture && !s_q.underrun)
    else $error("buffer popped without snapshot");
endmodule // bsl_slave
`default_nettype wire

// ===== verification/bsl_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module bsl_master_model (
  input wire logic i_go,
  input wire logic i_mc_on,
  input wire logic i_line,
  output logic o_clk,
  output logic o_done,
  output logic [63:0] o_word,
  output logic o_reg_bit,
  output logic o_mc_bit,
  output logic o_crc_ok,
  output logic o_frame_ok,
  output logic [5:0] o_delay
);
  logic [72:0] bits;
  logic [5:0] crc;
  logic fb;
  int n;
  int k;

  // One slave on this link; clock stands high between frames, 80 ns per bit
  initial begin
    o_clk = 1'h1;
    o_done = 1'h0;
    forever begin
      wait (i_go === 1'h1);
      wait (i_line === 1'h1);
      #7;
      // Reg bit, 64 data, optional slow bit, 6 CRC and the stop bit
      n = i_mc_on ? 73 : 72;
      o_delay = 6'h00;
      #40 o_clk = 1'h0;
      #40 o_clk = 1'h1;
      #40 o_clk = 1'h0;
      // Ack length stands in for the measured line delay
      while (i_line !== 1'h1 && o_delay < 6'h20) begin
        o_delay = o_delay + 6'h01;
        #40 o_clk = 1'h1;
        #40 o_clk = 1'h0;
      end
      o_frame_ok = (i_line === 1'h1);
      for (k = 0; k < n; k++) begin
        #40 o_clk = 1'h1;
        #40 o_clk = 1'h0;
        bits[k] = i_line;
      end
      #40 o_clk = 1'h1;
      // Spare edge lets the slave settle into its done state
      #40 o_clk = 1'h0;
      #40 o_clk = 1'h1;
      // Serial CRC over reg, data and optional slow bit
      crc = 6'h00;
      for (k = 0; k < n - 7; k++) begin
        fb = crc[5] ^ bits[k];
        crc = {crc[4:0], 1'h0} ^ (fb ? 6'h03 : 6'h00);
      end
      o_crc_ok = 1'h1;
      for (k = 0; k < 6; k++) begin
        if (bits[n - 7 + k] !== ~crc[5 - k])
          o_crc_ok = 1'h0;
      end
      o_frame_ok = o_frame_ok && (bits[n - 1] === 1'h0);
      o_reg_bit = bits[0];
      for (k = 0; k < 64; k++) begin
        o_word[63 - k] = bits[1 + k];
      end
      o_mc_bit = i_mc_on ? bits[65] : 1'h0;
      o_done = 1'h1;
      wait (i_go === 1'h0);
      o_done = 1'h0;
    end
  end
endmodule // bsl_master_model
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [63:0] data;
    logic mc_en;
    logic mc_bit;
  } bsl_row_type;
  localparam logic [63:0] BASE = 64'h1000_0000_0000_0000;
  bsl_row_type rows [3] = '{'{64'h8000_0000_0000_0001, 1'h0, 1'h1},
    '{64'h0123_4567_89ab_cdef, 1'h1, 1'h1}, '{64'hfedc_ba98_7654_3210, 1'h1, 1'h0}};
  logic i_clk_sys = 1'h0;
  logic i_rst = 1'h1;
  logic mclk, line, pos_valid, pos_ready, mc_en, mc_bit, capture, underrun;
  logic [63:0] pos_data, m_word;
  logic [7:0] reg_byte;
  logic go, mc_on, done, m_reg, m_mc, m_crc, m_fok;
  logic [5:0] m_delay;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  int cap_n = 0;
  int und_n = 0;
  int fr = 0;
  int i;

  // System clock, 100 ns period
  always #50 i_clk_sys = ~i_clk_sys;

  bsl_slave u_bsl_slave (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_master_clock_line(mclk),
    .o_slave_return_line(line), .i_pos_valid(pos_valid), .i_pos_data(pos_data), .o_pos_ready(pos_ready),
    .i_mc_enable(mc_en), .i_mc_bit(mc_bit), .i_reg_byte(reg_byte), .o_capture(capture), .o_underrun(underrun));
  bsl_master_model u_bsl_master_model (.i_go(go), .i_mc_on(mc_on), .i_line(line), .o_clk(mclk), .o_done(done),
    .o_word(m_word), .o_reg_bit(m_reg), .o_mc_bit(m_mc), .o_crc_ok(m_crc), .o_frame_ok(m_fok), .o_delay(m_delay));

  task give_verdict;
    $display("Checks %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Pulse tally and hang guard, sampled mid-cycle where pulses stand;
  // run needs about 10100 cycles
  always @(negedge i_clk_sys) begin
    cyc++;
    if (capture === 1'h1)
      cap_n++;
    if (underrun === 1'h1)
      und_n++;
    if (cyc == 16000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic wait_high(input int lim);
    int n;
    n = 0;
    while (line !== 1'h1 && n < lim) begin
      @(negedge i_clk_sys);
      n++;
    end
    check("line ready", 1, line);
  endtask

  task automatic push(input logic [63:0] d);
    @(negedge i_clk_sys);
    check("pos ready", 1, pos_ready);
    pos_valid = 1'h1;
    pos_data = d;
    @(negedge i_clk_sys);
    pos_valid = 1'h0;
  endtask

  // One link frame; the slow-bit inputs are held until the next frame
  task automatic frame(input logic [63:0] w, input logic me, input logic mb, input int und);
    int c0;
    int u0;
    int n;
    c0 = cap_n;
    u0 = und_n;
    @(negedge i_clk_sys);
    mc_en = me;
    mc_bit = mb;
    mc_on = me;
    go = 1'h1;
    n = 0;
    while (done !== 1'h1 && n < 2000) begin
      @(negedge i_clk_sys);
      n++;
    end
    check("frame done", 1, done);
    go = 1'h0;
    repeat (2) @(negedge i_clk_sys);
    check("word", w, m_word);
    check("reg bit", reg_byte[7 - (fr % 8)], m_reg);
    check("mc bit", me & mb, m_mc);
    check("crc", 1, m_crc);
    check("framing", 1, m_fok);
    check("ack length", 1, m_delay != 6'h00 && m_delay < 6'h20);
    check("capture pulses", c0 + 1, cap_n);
    check("underrun pulses", u0 + und, und_n);
    fr++;
    repeat (150) @(negedge i_clk_sys);
    check("idle low", 0, line);
    wait_high(120);
  endtask

  initial begin
    pos_valid = 1'h0;
    pos_data = 64'h0;
    mc_en = 1'h0;
    mc_bit = 1'h0;
    reg_byte = 8'hc6;
    go = 1'h0;
    mc_on = 1'h0;
    repeat (6) @(negedge i_clk_sys);
    i_rst = 1'h0;
    wait_high(260);
    // Ordinary frames, no command exchange beforehand
    for (i = 0; i < 3; i++) begin
      push(rows[i].data);
      frame(rows[i].data, rows[i].mc_en, rows[i].mc_bit, 0);
    end
    $display("test rows done");
    // Fill buffer until it refuses, then drain it in order
    for (i = 0; i < 32; i++)
      push(BASE + 64'(i));
    @(negedge i_clk_sys);
    check("ready when full", 0, pos_ready);
    for (i = 0; i < 32; i++) begin
      frame(BASE + 64'(i), 1'h0, 1'h0, 0);
      if (i == 0)
        check("ready after pop", 1, pos_ready);
    end
    $display("test fill drain done");
    // Empty buffer at capture resends last word
    frame(BASE + 64'h1f, 1'h0, 1'h0, 1);
    $display("test underrun done");
    // Reset in mid-run, then timeout again
    @(negedge i_clk_sys);
    i_rst = 1'h1;
    @(negedge i_clk_sys);
    check("rst line", 0, line);
    check("rst ready", 1, pos_ready);
    check("rst capture", 0, capture);
    check("rst underrun", 0, underrun);
    i_rst = 1'h0;
    // Line still low after 199 cycles and high after the 200th
    repeat (199) @(negedge i_clk_sys);
    check("timeout low", 0, line);
    @(negedge i_clk_sys);
    check("timeout end", 1, line);
    $display("test reset done");
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
